// File: core/wdt_pkg.sv
// Purpose: Shared constants and carrier types of the watchdog with trap.
// Assumes: clk is the high-frequency clock; every input is on clk.
// Notes:   Function
// Function
// - Enable bit and counting are active straight out of reset.
// - While disabled the binary counter stages stay at zero.
// - Action select zero turns an overflow into a watchdog NMI request.
// - The watchdog NMI cannot be masked by the global interrupt flag.
// - A new watchdog NMI is taken at once, even during service.
// - Action select one turns an overflow into a reset pulse.
// - Watchdog reset pulse lasts at most 24 high-frequency clocks.
// - Command D2 commits trap area, 4E clears, B1 disables once the enable bit is clear; rest ignored.
// - A new RAM trap setting acts only after command D2.
// - RAM fetches trap only when the committed RAM trap bit is one.
// - Fetches from special or bank register areas always trap.
// - Trap action zero turns a trapping fetch into a trap NMI.
// - The trap NMI cannot be masked by the global interrupt flag.
// - A new trap NMI is taken at once, even during service.
// - Trap action one turns a trapping fetch into a reset pulse.
// - Trap reset pulse lasts at most 24 high-frequency clocks.
// - Trap controls share the watchdog config and command addresses.
// - Clear code resets the binary counter only, never the divider.
// - Once action select is zero, writes cannot set it back.
// - Counting pauses in stop, idle and sleep, then resumes.
// - Timeout codes 00..11 give 2^25..2^19 fc or 2^17..2^11 fs.
package wdt_pkg;

  // Register offsets
  localparam logic [7:0] CFG_OFF    = 8'h34;
  localparam logic [7:0] CMD_OFF    = 8'h35;
  localparam logic [7:0] STATUS_OFF = 8'h36;

  // Command codes
  localparam logic [7:0] CODE_TRAP_COMMIT = 8'hD2;
  localparam logic [7:0] CODE_CLEAR       = 8'h4E;
  localparam logic [7:0] CODE_DISABLE     = 8'hB1;

  // Configuration field positions
  localparam int CFG_WD_ACT_BIT   = 0;
  localparam int CFG_TSEL_LSB     = 1;
  localparam int CFG_EN_BIT       = 3;
  localparam int CFG_TRAP_ACT_BIT = 4;
  localparam int CFG_RAM_SEL_BIT  = 5;

  // Divider lengths: overflow is divider period times four
  localparam int HF_DIV_LOG2_DEF = 23;
  localparam int LF_DIV_LOG2_DEF = 15;
  localparam logic [1:0] BIN_LAST = 2'h3;

  // Reset pulse time in high-frequency clock periods
  localparam int RST_MAX_FC_PERIODS = 24;
  localparam int FC_PERIOD_NS       = 8;
  localparam int CLK_PERIOD_NS      = 8;
  localparam int RST_CYCLES_INT     =
    RST_MAX_FC_PERIODS * FC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [4:0] RST_CYCLES = 5'(RST_CYCLES_INT);

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_type;

  // Instruction fetch region flags
  typedef struct packed {
    logic valid;
    logic in_ram;
    logic in_sfr;
    logic in_dbr;
  } fetch_type;

  // Whole state of the watchdog core
  typedef struct packed {
    logic       en_bit;
    logic       running;
    logic [1:0] tsel;
    logic       wd_act;
    logic       trap_act;
    logic       ram_sel_stage;
    logic       ram_sel;
    logic [1:0] bincnt;
    logic       wd_nmi;
    logic       trap_nmi;
    logic       rst_active;
    logic [4:0] rst_cnt;
    logic [7:0] rdata;
  } wd_state_type;

  localparam wd_state_type STATE_RESET = '{
    en_bit:        1'b1,
    running:       1'b1,
    tsel:          2'h0,
    wd_act:        1'b1,
    trap_act:      1'b1,
    ram_sel_stage: 1'b1,
    ram_sel:       1'b1,
    bincnt:        2'h0,
    wd_nmi:        1'b0,
    trap_nmi:      1'b0,
    rst_active:    1'b0,
    rst_cnt:       5'h00,
    rdata:         8'h00
  };

endpackage : wdt_pkg

// File: core/wd_divider.sv
// Purpose: Internal divider that paces the watchdog binary counter.
// Assumes: fs_tick is a one-cycle strobe on clk at the low frequency.
// Notes:   The divider is never cleared by software, only by reset.
`timescale 1ns/100ps
module wd_divider
  import wdt_pkg::*;
#(
  parameter int HF_DIV_LOG2 = HF_DIV_LOG2_DEF,
  parameter int LF_DIV_LOG2 = LF_DIV_LOG2_DEF
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Control
  input  wire logic       run,
  input  wire logic       use_lf,
  input  wire logic       fs_tick,
  input  wire logic [1:0] tsel,
  // Result
  output logic            tick
);

  localparam int W = HF_DIV_LOG2;

  // Every timeout code takes two bits off the divider
  initial begin
    if (LF_DIV_LOG2 < 7 || HF_DIV_LOG2 < LF_DIV_LOG2 || W > 40) begin
      $error("wd_divider: divider lengths out of range");
    end
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } div_state_type;

  div_state_type st_q;
  div_state_type st_d;
  logic          step;
  logic [5:0]    shift;
  logic [W-1:0]  mask;

  // Divider stepping and stage select
  always_comb begin
    st_d  = st_q;
    step  = run && (!use_lf || fs_tick);
    shift = use_lf ? 6'(LF_DIV_LOG2 - 2 * int'(tsel))
                   : 6'(HF_DIV_LOG2 - 2 * int'(tsel));
    mask  = {W{1'b1}} >> (6'(W) - shift);
    tick  = step && ((st_q.cnt & mask) == mask);
    if (step) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : wd_divider

// File: core/wd_trap_core.sv
// Purpose: Watchdog timer with address-trap supervision and reset pulse.
// Assumes: Core fetch flags, mode inputs and the register port run on clk.
// Notes:   Config and command are write-only; a status word is readable.
`timescale 1ns/100ps
module wd_trap_core
  import wdt_pkg::*;
#(
  parameter int HF_DIV_LOG2 = HF_DIV_LOG2_DEF,
  parameter int LF_DIV_LOG2 = LF_DIV_LOG2_DEF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register port
  input  wire bus_req_type bus,
  output logic [7:0]       rdata,
  // Core fetch and modes
  input  wire fetch_type   fetch,
  input  wire logic        low_power_hold,
  input  wire logic        divider_stage_select,
  input  wire logic        low_speed_mode_one,
  input  wire logic        fs_tick,
  // Requests to the core
  output logic             wd_nmi_request,
  output logic             trap_nmi_request,
  output logic             hw_reset_req,
  output logic             hf_osc_restart,
  // Open-drain reset pin
  output logic             rst_pin_o,
  output logic             rst_pin_oe
);

  initial begin
    if (RST_CYCLES_INT < 1 || RST_CYCLES_INT > 31) begin
      $error("wd_trap_core: reset pulse length out of range");
    end
  end

  wd_state_type st_q;
  wd_state_type st_d;
  logic         tick;
  logic         cfg_wr;
  logic         cmd_wr;
  logic         ovf;
  logic         trap;
  logic         rst_fire;

  // Divider runs only while enabled and not in a low-power mode
  wd_divider #(
    .HF_DIV_LOG2 (HF_DIV_LOG2),
    .LF_DIV_LOG2 (LF_DIV_LOG2)
  ) u_div (
    .clk     (clk),
    .rstn    (rstn),
    .run     (st_q.running && !low_power_hold),
    .use_lf  (divider_stage_select || low_speed_mode_one),
    .fs_tick (fs_tick),
    .tsel    (st_q.tsel),
    .tick    (tick)
  );

  // Address decode, overflow and trap detection
  always_comb begin
    cfg_wr = bus.wr && (bus.addr == CFG_OFF);
    cmd_wr = bus.wr && (bus.addr == CMD_OFF);
    ovf    = tick && (st_q.bincnt == BIN_LAST);
    trap   = fetch.valid && (fetch.in_sfr || fetch.in_dbr
             || (fetch.in_ram && st_q.ram_sel));
    rst_fire = !st_q.rst_active && ((ovf && st_q.wd_act)
               || (trap && st_q.trap_act));
  end

  // Next state of the whole block
  always_comb begin
    st_d = st_q;
    // Configuration write: trap area is only staged here
    if (cfg_wr) begin
      st_d.tsel          = bus.wdata[CFG_TSEL_LSB +: 2];
      st_d.en_bit        = bus.wdata[CFG_EN_BIT];
      st_d.trap_act      = bus.wdata[CFG_TRAP_ACT_BIT];
      st_d.ram_sel_stage = bus.wdata[CFG_RAM_SEL_BIT];
      st_d.wd_act = st_q.wd_act && bus.wdata[CFG_WD_ACT_BIT];
      if (bus.wdata[CFG_EN_BIT]) begin
        st_d.running = 1'b1;
      end
    end
    // Binary counter steps on each divider tick and wraps on overflow
    if (tick) begin
      st_d.bincnt = st_q.bincnt + 2'h1;
    end
    // Command decode; unknown codes leave everything alone
    if (cmd_wr) begin
      unique case (bus.wdata)
        CODE_TRAP_COMMIT: begin
          st_d.ram_sel = st_q.ram_sel_stage;
        end
        CODE_CLEAR: begin
          st_d.bincnt = 2'h0;
        end
        CODE_DISABLE: begin
          if (!st_q.en_bit) begin
            st_d.running = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // A stopped watchdog keeps its counter cleared
    if (!st_d.running) begin
      st_d.bincnt = 2'h0;
    end
    // Interrupt requests are one-cycle pulses, never gated or queued
    st_d.wd_nmi   = ovf && !st_q.wd_act;
    st_d.trap_nmi = trap && !st_q.trap_act;
    // Shared reset pulse timer for both sources
    if (rst_fire) begin
      st_d.rst_active = 1'b1;
      st_d.rst_cnt    = RST_CYCLES - 5'h01;
    end else if (st_q.rst_active) begin
      if (st_q.rst_cnt == 5'h00) begin
        st_d.rst_active = 1'b0;
      end else begin
        st_d.rst_cnt = st_q.rst_cnt - 5'h01;
      end
    end
    // Read data: status word only, others read as zero
    st_d.rdata = 8'h00;
    if (bus.rd && (bus.addr == STATUS_OFF)) begin
      st_d.rdata = {1'b0, st_q.rst_active, st_q.ram_sel, st_q.trap_act,
                    st_q.wd_act, st_q.running, st_q.bincnt};
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs
  assign rdata            = st_q.rdata;
  assign wd_nmi_request   = st_q.wd_nmi;
  assign trap_nmi_request = st_q.trap_nmi;
  assign hw_reset_req     = st_q.rst_active;
  assign hf_osc_restart   = st_q.rst_active && low_speed_mode_one;
  assign rst_pin_o        = 1'b0;
  assign rst_pin_oe       = st_q.rst_active;

  // Checks next to the logic
  AST_RESET_ENABLED: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> (st_q.running && st_q.en_bit && st_q.wd_act))
    else $error("watchdog not enabled after reset");

  AST_STOPPED_ZERO: assert property (
    @(posedge clk) disable iff (!rstn)
    !st_q.running |-> (st_q.bincnt == 2'h0))
    else $error("counter not zero while stopped");

  AST_DISABLE_NEEDS_BIT: assert property (
    @(posedge clk) disable iff (!rstn)
    (cmd_wr && bus.wdata == CODE_DISABLE && st_q.en_bit && st_q.running)
    |=> st_q.running)
    else $error("disable code took effect with enable bit set");

  AST_WD_NMI: assert property (
    @(posedge clk) disable iff (!rstn)
    (ovf && !st_q.wd_act && !rst_fire)
    |=> (wd_nmi_request && !$rose(rst_pin_oe)))
    else $error("overflow did not give watchdog NMI");

  AST_WD_RESET: assert property (
    @(posedge clk) disable iff (!rstn)
    (ovf && st_q.wd_act && !st_q.rst_active) |=> rst_pin_oe [*8])
    else $error("overflow did not hold reset pin low");

  AST_RESET_WIDTH: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(rst_pin_oe) |-> (rst_pin_oe && !rst_pin_o) ##24 !rst_pin_oe)
    else $error("reset pulse length wrong");

  AST_COMMIT: assert property (
    @(posedge clk) disable iff (!rstn)
    (cmd_wr && bus.wdata == CODE_TRAP_COMMIT)
    |=> (st_q.ram_sel == $past(st_q.ram_sel_stage)))
    else $error("trap area commit failed");

  AST_NO_EARLY_AREA: assert property (
    @(posedge clk) disable iff (!rstn)
    cfg_wr |=> $stable(st_q.ram_sel))
    else $error("trap area changed without commit");

  AST_CLEAR: assert property (
    @(posedge clk) disable iff (!rstn)
    (cmd_wr && bus.wdata == CODE_CLEAR) |=> (st_q.bincnt == 2'h0))
    else $error("clear code did not clear counter");

  AST_RAM_FREE: assert property (
    @(posedge clk) disable iff (!rstn)
    (fetch.valid && fetch.in_ram && !fetch.in_sfr && !fetch.in_dbr
     && !st_q.ram_sel) |=> !trap_nmi_request)
    else $error("RAM fetch trapped while allowed");

  AST_REG_AREA_TRAP: assert property (
    @(posedge clk) disable iff (!rstn)
    (fetch.valid && (fetch.in_sfr || fetch.in_dbr) && !st_q.trap_act)
    |=> trap_nmi_request)
    else $error("register area fetch did not trap");

  AST_TRAP_RESET: assert property (
    @(posedge clk) disable iff (!rstn)
    (trap && st_q.trap_act && !st_q.rst_active)
    |=> (rst_pin_oe && hw_reset_req && !trap_nmi_request))
    else $error("trap did not start reset pulse");

  AST_ACT_LOCK: assert property (
    @(posedge clk) disable iff (!rstn)
    !st_q.wd_act |=> !st_q.wd_act)
    else $error("action select returned to reset");

  AST_HOLD: assert property (
    @(posedge clk) disable iff (!rstn)
    (low_power_hold && !cmd_wr) |=> $stable(st_q.bincnt))
    else $error("counter moved during low-power hold");

  AST_ODD_CODE: assert property (
    @(posedge clk) disable iff (!rstn)
    (cmd_wr && bus.wdata != CODE_TRAP_COMMIT && bus.wdata != CODE_CLEAR
     && bus.wdata != CODE_DISABLE)
    |=> ($stable(st_q.ram_sel) && $stable(st_q.running)))
    else $error("unknown command code changed state");

  AST_RAM_TRAP: assert property (
    @(posedge clk) disable iff (!rstn)
    (fetch.valid && fetch.in_ram && st_q.ram_sel && !st_q.trap_act)
    |=> trap_nmi_request)
    else $error("RAM fetch did not trap while forbidden");

  AST_TRAP_NMI: assert property (
    @(posedge clk) disable iff (!rstn)
    (trap && !st_q.trap_act && !rst_fire)
    |=> (trap_nmi_request && !$rose(rst_pin_oe)))
    else $error("trapping fetch did not give trap NMI");

endmodule : wd_trap_core

// File: tb/cpu_core_model.sv
// Purpose: Core model that issues instruction fetches into chosen regions.
// Assumes: go is a one-cycle request on clk; region is {ram, sfr, bank}.
// Notes:   Between fetches the region flags toggle so stale values never
//          look like a real fetch.
`timescale 1ns/100ps
module cpu_core_model
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Request from the bench
  input  wire logic       go,
  input  wire logic [2:0] region,
  // Fetch toward the block
  output fetch_type       fetch
);
  // One fetch a cycle after go, region flags beside it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetch <= '0;
    end else if (go) begin
      fetch <= {1'b1, region};
    end else begin
      fetch <= {1'b0, ~fetch[2:0]};
    end
  end
endmodule : cpu_core_model

// File: tb/watchdog_with_address_trap_test.sv
// Purpose: Self-checking bench of the watchdog with address trap.
// Assumes: Short divider (9/7) so timeout code 11 overflows every 32 clk.
// Notes:   Random fetch regions come from a fixed seed.
`timescale 1ns/100ps
module watchdog_with_address_trap_test;
  import wdt_pkg::*;
  logic        clk, rstn, go, hold, dss, lsm, fs_tick;
  logic [2:0]  region;
  bus_req_type bus;
  fetch_type   fetch;
  logic [7:0]  rdata, v, n;
  logic        wd_nmi, trap_nmi, rst_req, osc_rst, pin_o, pin_oe;
  int          err_count, tests_run, seed, i;

  // Design and core model
  wd_trap_core #(.HF_DIV_LOG2(9), .LF_DIV_LOG2(7)) DUT (.clk(clk),
    .rstn(rstn), .bus(bus), .rdata(rdata), .fetch(fetch),
    .low_power_hold(hold), .divider_stage_select(dss),
    .low_speed_mode_one(lsm), .fs_tick(fs_tick), .wd_nmi_request(wd_nmi),
    .trap_nmi_request(trap_nmi), .hw_reset_req(rst_req),
    .hf_osc_restart(osc_rst), .rst_pin_o(pin_o), .rst_pin_oe(pin_oe));
  cpu_core_model core (.clk(clk), .rstn(rstn), .go(go), .region(region),
    .fetch(fetch));

  // Clock and a slow-source strobe
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    fs_tick = 1'b0;
    forever @(posedge clk) fs_tick <= ~fs_tick;
  end

  // Expected trap for a fetch region
  function automatic logic exp_trap(input logic [2:0] r, input logic ram);
    return r[1] | r[0] | (r[2] & ram);
  endfunction : exp_trap

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) bus <= '0;
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
    @(posedge clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk) bus <= '0;
    #1 chk(nm, e, rdata);
  endtask : rd_chk

  // One fetch, then count NMI, reset and restart cycles
  task automatic fetch_chk(input logic [2:0] r, input logic [7:0] en,
                           input logic [7:0] er);
    logic [7:0] cn, cr, co;
    cn = 0;
    cr = 0;
    co = 0;
    @(posedge clk) go <= 1'b1;
    region <= r;
    @(posedge clk) go <= 1'b0;
    repeat (40) begin
      @(posedge clk) #1;
      cn += trap_nmi;
      cr += pin_oe & rst_req & ~pin_o;
      co += osc_rst;
    end
    chk("trap nmi", en, cn);
    chk("trap reset", er, cr);
    chk("osc restart", lsm ? er : 8'h00, co);
  endtask : fetch_chk

  // Cycles until the chosen watchdog event, 200 when none
  task automatic wait_ev(input bit nmi, output logic [7:0] c);
    c = 0;
    do begin
      @(posedge clk) #1;
      c++;
    end while ((nmi ? wd_nmi : rst_req) !== 1'b1 && c < 200);
  endtask : wait_ev

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {rstn, go, hold, dss, lsm} = '0;
    region = 3'h0;
    bus = '0;
    seed = 14;
    err_count = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_chk("status reset", STATUS_OFF, 8'h3C);
    rd_chk("config read", CFG_OFF, 8'h00);
    rd_chk("unmapped read", 8'h50, 8'h00);
    wr(CMD_OFF, CODE_CLEAR);
    wr(CFG_OFF, 8'h37);
    wr(CMD_OFF, CODE_DISABLE);
    repeat (100) @(posedge clk);
    rd_chk("status off", STATUS_OFF, 8'h38);
    // Trap reset from each region, slow mode on the RAM one
    for (i = 0; i < 3; i++) begin
      lsm <= (i == 0);
      fetch_chk(3'b100 >> i, 8'h00, 8'd24);
    end
    lsm <= 1'b0;
    wr(CFG_OFF, 8'h07);
    fetch_chk(3'b100, 8'h01, 8'h00);
    wr(CMD_OFF, 8'h5A);
    fetch_chk(3'b100, 8'h01, 8'h00);
    wr(CMD_OFF, CODE_TRAP_COMMIT);
    rd_chk("status commit", STATUS_OFF, 8'h08);
    for (i = 0; i < 12; i++) begin
      v = 8'($random(seed));
      n = {7'h0, exp_trap(v[2:0], 1'b0)};
      fetch_chk(v[2:0], n, 8'h00);
    end
    // Watchdog reset action, disable code ignored while enabled
    wr(CFG_OFF, 8'h0F);
    wr(CMD_OFF, CODE_DISABLE);
    wr(CMD_OFF, CODE_CLEAR);
    wait_ev(1'b0, n);
    chk("first overflow", 8'h01, {7'h0, n >= 24 && n <= 34});
    n = 0;
    while (rst_req === 1'b1 && n < 40) begin
      @(posedge clk) #1;
      n++;
    end
    chk("wd reset width", 8'd24, n);
    // Counting pauses while held
    wr(CMD_OFF, CODE_CLEAR);
    hold <= 1'b1;
    n = 0;
    repeat (100) begin
      @(posedge clk) #1;
      n += rst_req;
    end
    chk("reset in hold", 8'h00, n);
    hold <= 1'b0;
    wait_ev(1'b0, n);
    chk("resume", 8'h01, {7'h0, n <= 34});
    // NMI action, one-way select
    wr(CFG_OFF, 8'h0E);
    wr(CMD_OFF, CODE_CLEAR);
    wait_ev(1'b1, n);
    chk("wd nmi", 8'h01, {7'h0, n <= 34});
    wait_ev(1'b1, n);
    chk("nmi period", 8'd32, n);
    wr(CFG_OFF, 8'h0F);
    wait_ev(1'b0, n);
    chk("no reset", 8'd200, n);
    // Slow source: code 11 gives 8 slow ticks, 16 clk at this strobe
    dss <= 1'b1;
    wait_ev(1'b1, n);
    wait_ev(1'b1, n);
    chk("slow nmi period", 8'd16, n);
    report_and_stop();
  end
endmodule : watchdog_with_address_trap_test
